// [shared/conv_ctrl_map.vh]
// register map and field positions of the conversion control block
`ifndef CONV_CTRL_MAP_VH
`define CONV_CTRL_MAP_VH
`define OFS_CSC1 4'h0
`define OFS_CSC2 4'h4
`define OFS_RESULT_LOW 4'h8
`define OFS_IRQ_STATUS 4'hC
`define OFS_IRQ_MASK 4'h0
`define ADDR_BITS 4
`define BIT_DONE 7
`define BIT_IRQ_EN 6
`define BIT_CONT 5
`define BIT_ACTIVE 7
`define BIT_TRIG_SEL 6
`define BIT_CMP_EN 5
`define BIT_CMP_GE 4
`define SEL_MSB 4
`define SEL_LAST_INPUT 5'h1B
`define SEL_RESERVED 5'h1C
`define SEL_HIGH_REF 5'h1D
`define SEL_LOW_REF 5'h1E
`define SEL_OFF 5'h1F
`define CSC1_RESET 8'h1F
`define CSC2_RESET 8'h00
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define IRQ_BITS 2
`define IRQ_DONE 0
`define IRQ_CMP_MISS 1
`endif

// [src/conv_ctrl_status.v]
// control and status registers of a successive-approximation converter
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`include "conv_ctrl_map.vh"
`default_nettype none
module conv_ctrl_status
(
   // clock, reset, enable
   input wire aclk,
   input wire aresetn,
   input wire clk_en,
   // axi4-lite write address
   input wire [`ADDR_BITS-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [`ADDR_BITS-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // hardware trigger from periodic counter, same clock
   input wire hw_trigger_in,
   // converter datapath
   output reg conv_start,
   output reg conv_abort,
   output reg [4:0] input_select,
   output reg [4:0] analog_input_index,
   output reg select_input,
   output reg select_high_reference,
   output reg select_low_reference,
   output reg converter_power_on,
   output reg compare_enable,
   output reg compare_greater_equal,
   input wire conv_finish,
   input wire compare_true,
   input wire [7:0] result_low_data,
   output reg result_low_read,
   // interrupt
   output wire irq
);

   //------------------------------------------------------------
   // registers
   //------------------------------------------------------------
   reg [7:0] csc1_r;
   reg [5:4] csc2_r;
   reg trig_sel_r;
   reg active_r;
   reg cont_run_r;
   reg [`IRQ_BITS-1:0] irq_status_r;
   reg aw_done_r;
   reg w_done_r;
   reg [`ADDR_BITS-1:0] aw_addr_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;

   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire have_aw = aw_done_r | aw_take;
   wire have_w = w_done_r | w_take;
   wire [`ADDR_BITS-1:0] wa = aw_take ? s_axi_awaddr : aw_addr_r;
   wire [31:0] wd = w_take ? s_axi_wdata : wdata_r;
   wire [3:0] ws = w_take ? s_axi_wstrb : wstrb_r;
   wire wr_do = clk_en & have_aw & have_w & ~s_axi_bvalid;
   wire wr_csc1 = wr_do & (wa == `OFS_CSC1) & ws[0];
   wire wr_csc2 = wr_do & (wa == `OFS_CSC2) & ws[0];
   wire wr_stat = wr_do & (wa == `OFS_IRQ_STATUS) & ws[0];
   wire rd_do = clk_en & s_axi_arvalid & ~s_axi_rvalid;
   wire rd_low = rd_do & (s_axi_araddr == `OFS_RESULT_LOW);

   assign s_axi_awready = clk_en & ~aw_done_r & ~s_axi_bvalid;
   assign s_axi_wready = clk_en & ~w_done_r & ~s_axi_bvalid;
   assign s_axi_arready = clk_en & ~s_axi_rvalid;

   //------------------------------------------------------------
   // conversion sequencing
   //------------------------------------------------------------
   wire [4:0] new_sel = wd[`SEL_MSB:0];
   wire sel_off_now = (csc1_r[`SEL_MSB:0] == `SEL_OFF);
   wire sw_start = wr_csc1 & (new_sel != `SEL_OFF) & ~trig_sel_r;
   wire hw_start = clk_en & trig_sel_r & hw_trigger_in & ~active_r & ~sel_off_now;
   wire finish = clk_en & active_r & conv_finish & ~wr_csc1;
   wire cmp_ok = ~csc2_r[`BIT_CMP_EN] | compare_true;
   wire again = finish & csc1_r[`BIT_CONT] & ~sel_off_now;
   wire start_now = sw_start | hw_start | again;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         csc1_r <= `CSC1_RESET;
         csc2_r <= 2'b00;
         trig_sel_r <= 1'b0;
         active_r <= 1'b0;
         cont_run_r <= 1'b0;
         conv_start <= 1'b0;
         conv_abort <= 1'b0;
         result_low_read <= 1'b0;
         irq_status_r <= {`IRQ_BITS{1'b0}};
      end
      else if (clk_en)
      begin
         conv_start <= start_now;
         conv_abort <= wr_csc1 & active_r;
         result_low_read <= rd_low;
         // done flag: set wins over the result read clear; a CSC1 write masks finish and clears it
         if (finish & cmp_ok)
            csc1_r[`BIT_DONE] <= 1'b1;
         else if (wr_csc1 | rd_low)
            csc1_r[`BIT_DONE] <= 1'b0;
         if (wr_csc1)
            csc1_r[6:0] <= wd[6:0];
         if (wr_csc2)
         begin
            trig_sel_r <= wd[`BIT_TRIG_SEL];
            csc2_r <= wd[5:4];
         end
         // active flag
         if (start_now)
            active_r <= 1'b1;
         else if (finish | wr_csc1)
            active_r <= 1'b0;
         cont_run_r <= start_now ? 1'b1 : ((finish & ~again) | wr_csc1) ? 1'b0 : cont_run_r;
         irq_status_r <= (irq_status_r & ~(wr_stat ? wd[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}}))
            | {finish & ~cmp_ok, finish & cmp_ok};
      end
   end

   //------------------------------------------------------------
   // select decode and power
   //------------------------------------------------------------
   always @*
   begin
      input_select = csc1_r[`SEL_MSB:0];
      analog_input_index = csc1_r[`SEL_MSB:0];
      select_input = (csc1_r[`SEL_MSB:0] <= `SEL_LAST_INPUT);
      select_high_reference = (csc1_r[`SEL_MSB:0] == `SEL_HIGH_REF);
      select_low_reference = (csc1_r[`SEL_MSB:0] == `SEL_LOW_REF);
      converter_power_on = ~sel_off_now & (active_r | cont_run_r);
      compare_enable = csc2_r[`BIT_CMP_EN];
      compare_greater_equal = csc2_r[`BIT_CMP_GE];
   end

   assign irq = csc1_r[`BIT_DONE] & csc1_r[`BIT_IRQ_EN];

   //------------------------------------------------------------
   // axi4-lite slave
   //------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_done_r <= 1'b0;
         w_done_r <= 1'b0;
         aw_addr_r <= {`ADDR_BITS{1'b0}};
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         if (aw_take)
            aw_addr_r <= s_axi_awaddr;
         if (w_take)
         begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_do)
         begin
            aw_done_r <= 1'b0;
            w_done_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wa == `OFS_CSC1 || wa == `OFS_CSC2 || wa == `OFS_IRQ_STATUS) ? `RESP_OKAY : `RESP_SLVERR;
         end
         else
         begin
            aw_done_r <= have_aw;
            w_done_r <= have_w;
            if (s_axi_bvalid & s_axi_bready)
               s_axi_bvalid <= 1'b0;
         end
         if (rd_do)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            case (s_axi_araddr)
               `OFS_CSC1: s_axi_rdata <= {24'h00_0000, csc1_r};
               `OFS_CSC2: s_axi_rdata <= {24'h00_0000, active_r, trig_sel_r, csc2_r, 4'h0};
               `OFS_RESULT_LOW: s_axi_rdata <= {24'h00_0000, result_low_data};
               `OFS_IRQ_STATUS: s_axi_rdata <= {30'h0000_0000, irq_status_r};
               default:
               begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// [tb/conv_ctrl_chk.sv]
// assertion checker of the conversion control block
`default_nettype none
module conv_ctrl_chk (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // converter side
   input wire conv_start,
   input wire conv_finish,
   input wire [4:0] input_select,
   input wire [4:0] analog_input_index,
   input wire select_input,
   input wire select_high_reference,
   input wire select_low_reference,
   input wire converter_power_on,
   input wire irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_sel_in: assert property (input_select <= 5'h1B |-> select_input && analog_input_index == input_select)
      else $error("input decode");
   a_sel_rsvd: assert property (input_select == 5'h1C |-> !select_input && !select_high_reference)
      else $error("reserved decode");
   a_sel_high: assert property (input_select == 5'h1D |-> select_high_reference && !select_low_reference)
      else $error("high ref decode");
   a_sel_low: assert property (input_select == 5'h1E |-> select_low_reference && !select_input)
      else $error("low ref decode");
   a_off_dark: assert property (input_select == 5'h1F |-> !converter_power_on)
      else $error("powered while off");
   a_off_idle: assert property ($past(input_select) == 5'h1F && input_select == 5'h1F |-> !conv_start)
      else $error("start while off");
   a_irq_cause: assert property ($rose(irq) |-> $past(conv_finish))
      else $error("irq without finish");
   a_start_pwr: assert property (conv_start |-> ##[0:1] converter_power_on)
      else $error("start unpowered");
endmodule
bind conv_ctrl_status conv_ctrl_chk chk (.aclk, .aresetn, .conv_start, .conv_finish, .input_select,
   .analog_input_index, .select_input, .select_high_reference, .select_low_reference, .converter_power_on, .irq);
`default_nettype wire

// [tb/conv_model.sv]
// behavioural converter answering start requests
`default_nettype none
module conv_model (
   // control from the block
   input wire logic aclk,
   input wire logic conv_start,
   input wire logic conv_abort,
   input wire logic cmp_in,
   // converter answers
   output logic conv_finish = 1'b0,
   output logic compare_true = 1'b0,
   output logic [7:0] result_low_data
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   assign result_low_data = 8'h5A;
   // compare result only valid with finish, toggles elsewhere
   always @(posedge aclk)
   begin
      conv_finish <= cnt == 1;
      compare_true <= cnt == 1 ? cmp_in : !compare_true;
      // a write that aborts and restarts pulses both: the restart wins
      if (conv_start) cnt <= 12;
      else if (conv_abort) cnt <= 0;
      else if (cnt > 0) cnt <= cnt - 1;
   end
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench of the conversion control block
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hw_trigger_in, conv_start, conv_abort, cmp;
   logic select_input, select_high_reference, select_low_reference, converter_power_on, compare_enable, irq;
   logic compare_greater_equal, conv_finish, compare_true, result_low_read;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [4:0] input_select, analog_input_index;
   logic [7:0] result_low_data;
   int mismatches = 0, num_checks = 0, nfin = 0, k;
   conv_ctrl_status dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hw_trigger_in,
      .conv_start, .conv_abort, .input_select, .analog_input_index, .select_input, .select_high_reference,
      .select_low_reference, .converter_power_on, .compare_enable, .compare_greater_equal, .conv_finish,
      .compare_true, .result_low_data, .result_low_read, .irq);
   conv_model far (.aclk, .conv_start, .conv_abort, .cmp_in(cmp), .conv_finish, .compare_true, .result_low_data);
   initial
   begin
      aclk = 0;
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk) if (conv_finish) nfin <= nfin + 1;
   task chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("mismatch %0t %h %h", $time, g, e);
      end
   endtask
   task end_of_test;
      if (mismatches == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      logic ta, tw;
      ta = 0;
      tw = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      do
      begin
         @(posedge aclk);
         if (!ta && s_axi_awready)
         begin
            ta = 1;
            s_axi_awvalid <= 0;
         end
         if (!tw && s_axi_wready)
         begin
            tw = 1;
            s_axi_wvalid <= 0;
         end
      end
      while (!(ta && tw));
      do @(posedge aclk); while (!s_axi_bvalid);
      chk(s_axi_bresp, 32'h0000_0000);
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge aclk); while (!s_axi_rvalid);
      chk(s_axi_rdata, {24'h00_0000, e});
      chk(s_axi_rresp, 32'h0000_0000);
   endtask
   task wt(input int n);
      repeat (300) if (nfin < n) @(posedge aclk);
      chk(nfin, n);
   endtask
   initial
   begin
      repeat (3000) @(posedge aclk);
      mismatches++;
      end_of_test;
   end
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, hw_trigger_in, cmp} = 6'h01;
      {clk_en, s_axi_bready, s_axi_rready} = 3'h7;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = {12'h00F, 32'h0000_0000};
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      rd(0, 8'h1F);
      rd(4, 8'h00);
      wr(0, 8'h43);
      rd(4, 8'h80);
      wt(1);
      rd(0, 8'hC3);
      chk(irq, 1);
      rd(8, 8'h5A);
      rd(0, 8'h43);
      wr(0, 8'h03);
      wt(2);
      chk(irq, 0);
      rd(0, 8'h83);
      wr(0, 8'h1F);
      rd(0, 8'h1F);
      cmp <= 0;
      wr(4, 8'h20);
      wr(0, 8'h03);
      wt(3);
      rd(0, 8'h03);
      rd(4, 8'h20);
      cmp <= 1;
      wr(4, 8'h50);
      chk(compare_greater_equal, 1);
      wr(0, 8'h43);
      repeat (30) @(posedge aclk);
      chk(nfin, 3);
      hw_trigger_in <= 1;
      @(posedge aclk);
      hw_trigger_in <= 0;
      wt(4);
      rd(0, 8'hC3);
      wr(4, 8'h00);
      wr(0, 8'h25);
      wt(7);
      wr(0, 8'h1F);
      repeat (2) @(posedge aclk);
      k = nfin;
      repeat (40) @(posedge aclk);
      chk(nfin, k);
      rd(4, 8'h00);
      end_of_test;
   end
endmodule
`default_nettype wire
